// [src/xcd_pkg.sv]
// Purpose: Shared constants and carriers for the discharge monitor and sense timing block
// Assumes: 10 MHz controller clock
// Notes:   Times are held in their own unit; cycle counts derive from them
package xcd_pkg;

	// ==========================================
	// Clock and timing
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned PULSE_NS         = 1000;     // Source pulse width
	localparam int unsigned SAMPLE_US        = 1000;     // Monitor sample interval
	localparam int unsigned GAP_MS           = 100;      // Burst gap wait
	localparam int unsigned RESET_MS         = 250;      // Short reset period
	localparam int unsigned OUT_SMP_NS       = 2500;     // Output sample delay
	localparam int unsigned PULSE_CYC        = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned SAMPLE_CYC       = SAMPLE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned GAP_CYC          = GAP_MS * (CLK_HZ / 1000);
	localparam int unsigned RESET_CYC        = RESET_MS * (CLK_HZ / 1000);
	localparam int unsigned OUT_SMP_CYC      = (OUT_SMP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned BURST_LEN        = 21;
	localparam int unsigned LL_PCT           = 12;       // Light-load threshold, percent

	// ==========================================
	// Widths
	localparam int unsigned CW               = 24;
	localparam int unsigned OW               = 16;
	localparam int unsigned AW               = 12;

	// ==========================================
	// Monitor states
	typedef enum logic [2:0] {
		XCD_IDLE   = 3'b000,
		XCD_PULSE  = 3'b001,
		XCD_SPACE  = 3'b010,
		XCD_GAP    = 3'b011,
		XCD_LOWPWR = 3'b100,
		XCD_DRAIN  = 3'b101,
		XCD_CHARGE = 3'b110
	} xcd_state_t;

	// Sense strobes toward the analogue side
	typedef struct packed {
		logic line_smp;
		logic cur_smp;
		logic out_smp;
	} xcd_strobe_t;

endpackage

// [src/xcd_ontime.sv]
// Purpose: Measures each on-time and raises the mid-point strobe next cycle
// Assumes: Turn-off is taken from the current-sense comparator or the gate output falling edge, whichever comes first
// Notes:   Previous on-time predicts the present mid-point
`timescale 1ns/100ps
module xcd_ontime #(
	parameter int unsigned OW = 16
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	// Switching cycle
	input  wire logic          on_i,
	// Mid-point strobe
	output logic               mid_o
);
	typedef struct packed {
		logic [OW-1:0] cnt;
		logic [OW-1:0] half;
		logic          on;
		logic          mid;
	} xcd_ot_t;

	xcd_ot_t s_q, s_d;

	always_comb begin
		s_d     = s_q;
		s_d.on  = on_i;
		s_d.mid = 1'b0;
		if (on_i) begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.cnt == s_q.half)
				s_d.mid = 1'b1;
		end else if (s_q.on) begin
			s_d.half = {1'b0, s_q.cnt[OW-1:1]};
			s_d.cnt  = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign mid_o = s_q.mid;
endmodule

// [src/xcd_top.sv]
// Purpose: Disconnect monitor bursts, reset-and-discharge sequence, sense sample timing
// Assumes: All inputs synchronous to clk_i; comparators live in the analogue stage
// Notes:   Ripple judged as swing of sampled source current within one burst
`timescale 1ns/100ps

// Functional notes
// - Sampled source current without enough swing across a burst flags a DC condition.
// - On a DC condition wait in low power, drain bias to its reset level, then restart the source.
// - Any steady DC level is treated as a disconnect so the restart cycle repeats.
// - The source is pulsed for a fixed width at a fixed sample interval while monitoring.
// - Pulses come in bursts of 21 separated by a burst gap wait.
// - Monitoring runs in latched fault mode and below the light-load threshold.
// - Monitoring is disabled above the light-load threshold unless in latched fault mode.
// - The line sample is adjusted to fall halfway through each on-time.
// - Switch current is sampled at the same mid-point and passed to limit logic.
// - The output sample comes a fixed delay after the detected turn-off.
// - Turn-off is taken from the current comparator, or from the gate output falling edge if that comes first.
// - Line samples happen only in on-time and output samples only in off-time.
// - The regulation reference is offset in proportion to peak current demand.
module xcd_top
	import xcd_pkg::*;
#(
	parameter int unsigned GAP_CYCLES   = GAP_CYC,
	parameter int unsigned RESET_CYCLES = RESET_CYC,
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
	parameter logic [AW-1:0] RIPPLE_MIN = 12'h040,
	parameter logic [AW-1:0] REF_BASE   = 12'h800,
	parameter logic [3:0]   REF_SHIFT   = 4'h3
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// Operating conditions
	input  wire logic              latched_fault_i,
	input  wire logic [6:0]        load_pct_i,
	input  wire logic              bias_at_reset_i,
	// Source current sense
	input  wire logic [AW-1:0]     hv_current_i,
	// Switching cycle
	input  wire logic              gate_output_i,
	input  wire logic              cs_trip_i,
	input  wire logic [AW-1:0]     peak_demand_i,
	input  wire logic [AW-1:0]     isw_adc_i,
	// Analogue controls
	output logic                   hv_source_on_o,
	output logic                   low_power_o,
	output logic                   bias_drain_o,
	output logic                   dc_flag_o,
	output xcd_pkg::xcd_strobe_t   strobe_o,
	output logic [AW-1:0]          mean_on_switch_current_o,
	output logic [AW-1:0]          reg_ref_o
);
	import xcd_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		xcd_state_t  st;
		logic [CW-1:0] tmr;
		logic [CW-1:0] pw;
		logic [4:0]  nsmp;
		logic [AW-1:0] imin;
		logic [AW-1:0] imax;
		logic        dc;
		logic        src;
		logic        lp;
		logic        drn;
		logic        on;
		logic [OW-1:0] offc;
		logic        offrun;
		xcd_strobe_t stb;
		logic [AW-1:0] isw;
		logic [AW-1:0] ref_v;
	} xcd_s_t;

	xcd_s_t s_q, s_d;
	logic   mid;
	logic   mon_en;

	function automatic logic [CW-1:0] cyc(input int unsigned n);
		return CW'(n - 1);
	endfunction

	assign mon_en = latched_fault_i || (load_pct_i < 7'(LL_PCT));

	xcd_ontime #(.OW(OW)) u_ontime (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.on_i    (s_q.on),
		.mid_o   (mid)
	);

	// ==========================================
	// Next state
	always_comb begin
		s_d     = s_q;
		s_d.stb = '0;
		s_d.tmr = (s_q.tmr != '0) ? s_q.tmr - 1'b1 : '0;
		// Length of the source pulse in progress, read by the width check
		s_d.pw  = s_q.src ? s_q.pw + 1'b1 : '0;
		case (s_q.st)
			XCD_IDLE: begin
				s_d.src = 1'b0;
				if (mon_en) begin
					s_d.st   = XCD_PULSE;
					s_d.tmr  = cyc(PULSE_CYC);
					s_d.src  = 1'b1;
					s_d.nsmp = '0;
					s_d.imin = '1;
					s_d.imax = '0;
				end
			end
			XCD_PULSE: begin
				if (s_q.tmr == '0) begin
					s_d.src  = 1'b0;
					s_d.nsmp = s_q.nsmp + 1'b1;
					if (hv_current_i < s_q.imin)
						s_d.imin = hv_current_i;
					if (hv_current_i > s_q.imax)
						s_d.imax = hv_current_i;
					s_d.st  = XCD_SPACE;
					s_d.tmr = cyc(SAMPLE_CYCLES - PULSE_CYC);
				end
			end
			XCD_SPACE: begin
				if (!mon_en) begin
					s_d.st = XCD_IDLE;
				end else if (s_q.nsmp == 5'(BURST_LEN)) begin
					if (s_q.imax - s_q.imin < RIPPLE_MIN) begin
						s_d.dc  = 1'b1;
						s_d.st  = XCD_LOWPWR;
						s_d.lp  = 1'b1;
						s_d.tmr = cyc(RESET_CYCLES);
					end else begin
						s_d.st   = XCD_GAP;
						s_d.nsmp = '0;
						s_d.tmr  = cyc(GAP_CYCLES);
					end
				end else if (s_q.tmr == '0) begin
					s_d.st  = XCD_PULSE;
					s_d.src = 1'b1;
					s_d.tmr = cyc(PULSE_CYC);
				end
			end
			XCD_GAP: begin
				if (!mon_en)
					s_d.st = XCD_IDLE;
				else if (s_q.tmr == '0) begin
					s_d.st   = XCD_PULSE;
					s_d.src  = 1'b1;
					s_d.tmr  = cyc(PULSE_CYC);
					s_d.imin = '1;
					s_d.imax = '0;
				end
			end
			XCD_LOWPWR: begin
				if (s_q.tmr == '0) begin
					s_d.lp  = 1'b0;
					s_d.drn = 1'b1;
					s_d.st  = XCD_DRAIN;
				end
			end
			XCD_DRAIN: begin
				if (bias_at_reset_i) begin
					s_d.drn = 1'b0;
					s_d.src = 1'b1;
					s_d.st  = XCD_CHARGE;
				end
			end
			XCD_CHARGE: begin
				// Restart logic elsewhere decides when bias is up
				if (!bias_at_reset_i) begin
					s_d.dc  = 1'b0;
					s_d.src = 1'b0;
					s_d.st  = XCD_IDLE;
				end
			end
			default: s_d.st = XCD_IDLE;
		endcase

		// Sense timing; on-time ends at comparator trip or gate fall, whichever comes first
		if (!s_q.on && gate_output_i && !cs_trip_i)
			s_d.on = 1'b1;
		else if (s_q.on && (cs_trip_i || !gate_output_i))
			s_d.on = 1'b0;
		if (mid && s_q.on) begin
			s_d.stb.line_smp = 1'b1;
			s_d.stb.cur_smp  = 1'b1;
			s_d.isw          = isw_adc_i;
		end
		if (s_q.on && !s_d.on) begin
			s_d.offrun = 1'b1;
			s_d.offc   = '0;
		end else if (s_q.offrun) begin
			s_d.offc = s_q.offc + 1'b1;
			if (s_d.on)
				s_d.offrun = 1'b0;
			else if (s_q.offc == OW'(OUT_SMP_CYC - 1)) begin
				s_d.stb.out_smp = 1'b1;
				s_d.offrun      = 1'b0;
			end
		end
		s_d.ref_v = REF_BASE + (peak_demand_i >> REF_SHIFT);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q      <= '0;
			s_q.st   <= XCD_IDLE;
			s_q.imin <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign hv_source_on_o           = s_q.src;
	assign low_power_o              = s_q.lp;
	assign bias_drain_o             = s_q.drn;
	assign dc_flag_o                = s_q.dc;
	assign strobe_o                 = s_q.stb;
	assign mean_on_switch_current_o = s_q.isw;
	assign reg_ref_o                = s_q.ref_v;

	// ==========================================
	// Checks
	a_pulse_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(hv_source_on_o) && $past(s_q.st) == XCD_PULSE |-> s_q.pw == CW'(PULSE_CYC))
		else $error("source pulse width wrong");
	a_line_in_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		strobe_o.line_smp |-> $past(s_q.on))
		else $error("line sample outside on-time");
	a_out_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		strobe_o.out_smp |-> !$past(s_q.on))
		else $error("output sample outside off-time");
	a_cur_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		strobe_o.line_smp == strobe_o.cur_smp)
		else $error("current and line strobes differ");
	a_trip_ends: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_q.on && cs_trip_i |=> !s_q.on)
		else $error("on-time not ended by trip");
	a_dc_lowpwr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(dc_flag_o) |-> low_power_o && !hv_source_on_o)
		else $error("dc flag without low power");
	a_mon_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!mon_en && s_q.st == XCD_SPACE |=> s_q.st == XCD_IDLE || s_q.st == XCD_LOWPWR)
		else $error("monitor not disabled");
	a_gap_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s_q.st == XCD_GAP |-> s_q.nsmp == 5'h00)
		else $error("burst count not cleared");
endmodule

// [test/xcd_stage.sv]
// Purpose: Power stage and mains model facing the monitor block
// Assumes: Mains ripple shows as alternating source current
// Notes:   Gate lags the current trip by three cycles
`timescale 1ns/100ps
module xcd_stage
	import xcd_pkg::*;
(
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_n_i,
	// Bench controls
	input  wire logic           ac_on_i,
	input  wire logic [7:0]     on_len_i,
	// Device controls
	input  wire logic           hv_source_on_i,
	input  wire logic           bias_drain_i,
	// Stage responses
	output logic [AW-1:0]       hv_current_o,
	output logic                bias_at_reset_o,
	output logic                gate_output_o,
	output logic                cs_trip_o
);
	logic [7:0] t_q;
	logic [2:0] d_q;
	logic       s_q;
	logic       a_q;

	// ==========================================
	// Switching cycle of 60 clocks
	assign gate_output_o   = (on_len_i != 8'h00) && (t_q < on_len_i + 8'h03);
	assign cs_trip_o       = gate_output_o && (t_q >= on_len_i);
	assign bias_at_reset_o = (d_q == 3'h5);

	// ==========================================
	// Source current and bias rail
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			t_q          <= 8'h00;
			d_q          <= 3'h0;
			s_q          <= 1'b0;
			a_q          <= 1'b0;
			hv_current_o <= 12'h000;
		end else begin
			t_q <= (t_q == 8'h3b) ? 8'h00 : t_q + 8'h01;
			s_q <= hv_source_on_i;
			// No current flows while the source is off
			if (!hv_source_on_i)
				hv_current_o <= 12'h000;
			else if (!s_q) begin
				// Mains phase moves on between pulses, so the level alternates
				hv_current_o <= !ac_on_i ? 12'h200 : (a_q ? 12'h300 : 12'h100);
				a_q          <= ~a_q;
			end
			if (hv_source_on_i)
				d_q <= 3'h0;
			else if (bias_drain_i && d_q != 3'h5)
				d_q <= d_q + 3'h1;
		end
	end
endmodule

// [test/test_xcd_top.sv]
// Purpose: Self-checking bench for the monitor and sense timing block
// Assumes: Shortened gap, reset and sample counts
// Notes:   Stage model supplies gate, trip, source current and bias
`timescale 1ns/100ps
module test_xcd_top;
	import xcd_pkg::*;
	logic            clk_i, rst_n_i, fault, ac_on, bias_rst, gate, trip;
	logic            hv_on, low_pwr, drain, dc_flag;
	logic [6:0]      load;
	logic [7:0]      on_len;
	logic [AW-1:0]   hv_cur, peak, isw, mean, ref_v;
	xcd_strobe_t     strb;
	int              miscompares, num_checks;

	xcd_top #(.GAP_CYCLES(50), .RESET_CYCLES(40), .SAMPLE_CYCLES(30)) dut (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .latched_fault_i(fault), .load_pct_i(load), .bias_at_reset_i(bias_rst),
		.hv_current_i(hv_cur), .gate_output_i(gate), .cs_trip_i(trip), .peak_demand_i(peak),
		.isw_adc_i(isw), .hv_source_on_o(hv_on), .low_power_o(low_pwr), .bias_drain_o(drain),
		.dc_flag_o(dc_flag), .strobe_o(strb), .mean_on_switch_current_o(mean), .reg_ref_o(ref_v));
	xcd_stage st (.clk_i(clk_i), .rst_n_i(rst_n_i), .ac_on_i(ac_on), .on_len_i(on_len),
		.hv_source_on_i(hv_on), .bias_drain_i(drain), .hv_current_o(hv_cur),
		.bias_at_reset_o(bias_rst), .gate_output_o(gate), .cs_trip_o(trip));

	// ==========================================
	// Shared tasks
	task automatic check(input logic [AW-1:0] got, input logic [AW-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic results();
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic setup(input logic f, input logic [6:0] l, input logic a);
		@(posedge clk_i);
		fault <= f;
		load  <= l;
		ac_on <= a;
	endtask
	// Load held high in reset so the monitor stays idle until a scenario starts it
	task automatic do_reset();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		load    <= 7'd50;
		fault   <= 1'b0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return hv_on;
			1: return dc_flag;
			default: return drain;
		endcase
	endfunction
	task automatic wait_for(input int w, input logic lvl, input int n, output int k);
		k = 0;
		while (pick(w) !== lvl && k < n) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		check(12'(pick(w)), 12'(lvl));
	endtask
	// Counts source pulses; bn and bh freeze at the first long idle stretch
	task automatic watch(input int n, output int r, output int bn, output int bh, output int m);
		int  hi;
		int  low;
		logic p;
		r = 0;
		bn = 0;
		bh = 0;
		m = 0;
		hi = 0;
		low = 0;
		p = hv_on;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			r += int'(hv_on && !p);
			hi += int'(hv_on);
			low = hv_on ? 0 : low + 1;
			m = (low > m) ? low : m;
			if (low == 31 && bn == 0) begin
				bn = r;
				bh = hi;
			end
			p = hv_on;
		end
	endtask

	// ==========================================
	// Scenarios
	task automatic load_high();
		int r, bn, bh, m;
		do_reset();
		setup(1'b0, 7'd50, 1'b1);
		watch(300, r, bn, bh, m);
		check(12'(r), 12'h000);
		setup(1'b1, 7'd50, 1'b1);
		watch(100, r, bn, bh, m);
		check(12'(r > 0), 12'h001);
		setup(1'b0, 7'd50, 1'b1);
		watch(100, r, bn, bh, m);
		check(12'(r), 12'h000);
		check(12'(hv_on), 12'h000);
	endtask
	task automatic burst_and_dc();
		int r, bn, bh, m, k;
		do_reset();
		setup(1'b0, 7'd5, 1'b1);
		wait_for(0, 1'b1, 100, k);
		watch(760, r, bn, bh, m);
		check(12'(bn), 12'h014);
		check(12'(bh), 12'h0d1);
		check(12'(m >= 50 && m <= 75), 12'h001);
		check(12'(dc_flag), 12'h000);
		setup(1'b0, 7'd5, 1'b0);
		wait_for(1, 1'b1, 2000, k);
		@(posedge clk_i);
		#1;
		check(12'(low_pwr), 12'h001);
		wait_for(2, 1'b1, 60, k);
		check(12'(k >= 37 && k <= 42), 12'h001);
		wait_for(0, 1'b1, 40, k);
		check(12'(bias_rst), 12'h001);
		wait_for(1, 1'b0, 100, k);
		wait_for(1, 1'b1, 3000, k);
	endtask
	task automatic sense();
		int len, nl, no;
		do_reset();
		@(posedge clk_i);
		peak <= 12'h120;
		isw  <= 12'h0a5;
		for (len = 20; len <= 30; len += 10) begin
			@(posedge clk_i);
			on_len <= 8'(len);
			repeat (130) @(posedge clk_i);
			#1;
			nl = 0;
			no = 0;
			repeat (60) begin
				@(posedge clk_i);
				#1;
				if (strb.line_smp) begin
					nl++;
					check(12'(st.t_q >= len / 2 && st.t_q <= len / 2 + 4), 12'h001);
					check(12'(gate), 12'h001);
					check(12'(strb.cur_smp), 12'h001);
				end
				if (strb.out_smp) begin
					no++;
					check(12'(st.t_q >= len + 24 && st.t_q <= len + 27), 12'h001);
					check(12'(gate), 12'h000);
				end
			end
			check(12'(nl * 16 + no), 12'h011);
			check(mean, isw);
			check(ref_v, 12'h824);
		end
	endtask

	// ==========================================
	// Clock, sequence and watchdog
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		miscompares = 0;
		num_checks = 0;
		rst_n_i = 1'b0;
		fault = 1'b0;
		load = 7'd50;
		ac_on = 1'b1;
		on_len = 8'h00;
		peak = 12'h000;
		isw = 12'h000;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		load_high();
		burst_and_dc();
		sense();
		results();
	end
	// Roughly six times the expected run
	initial begin
		#2_000_000;
		miscompares++;
		results();
	end
endmodule
